// file: design/burst_cache_access.v
// synchronous burst cache access logic: strobes, burst counter, byte writes
// assumes all pins but clock and reset arrive asynchronously and are resynchronised here;
// the two-way data and parity pins are resolved outside from the enables
`timescale 1ns/1ns
`default_nettype none
`include "burst_cache_defines.vh"

// Operation
// - all storage captures on rising edge only
// - processor strobe with select: load, read
// - controller strobe alone: load, write or read
// - select sampled only on loads; else deselect
// - continuation: step input alone picks address
// - step low: advance address before access
// - step high: keep address, access it again
// - low two bits xor count, upper bits fixed
// - continuation writes if any byte enable low
// - write only bytes whose enables are low
// - inputs sampled at edge; output enable too
// - data and parity float at power-up
module burst_cache_access (
    input  wire                clk_sys,
    input  wire                rst_b,
    input  wire [`ADDR_W-1:0]  addr_in,
    input  wire                chip_sel_n,
    input  wire                cpu_addr_strobe_n,
    input  wire                ctl_addr_strobe_n,
    input  wire                burst_step_n,
    input  wire                upper_byte_store_n,
    input  wire                lower_byte_store_n,
    input  wire                out_en_n,
    input  wire [`DATA_W-1:0]  data_in,
    output reg  [`DATA_W-1:0]  data_out,
    output reg                 data_oe,
    input  wire [`PAR_W-1:0]   parity_bits_in,
    output reg  [`PAR_W-1:0]   parity_bits_out,
    output reg                 parity_bits_oe,
    output reg                 read_queue_full_q
);

    // two-stage synchronisers; stage one is read only by stage two
    reg [`ADDR_W-1:0] addr_s1_q;
    reg [`ADDR_W-1:0] addr_s2_q;
    reg [`DATA_W-1:0] data_s1_q;
    reg [`DATA_W-1:0] data_s2_q;
    reg [`PAR_W-1:0]  par_s1_q;
    reg [`PAR_W-1:0]  par_s2_q;
    reg [6:0]         ctl_s1_q;
    reg [6:0]         ctl_s2_q;

    wire              sel_n;
    wire              cpu_stb_n;
    wire              ctl_stb_n;
    wire              step_n;
    wire              upper_n;
    wire              lower_n;
    wire              oe_n;

    // burst state
    reg [`ADDR_W-1:0] base_q;
    reg [`ADDR_W-1:0] base_d;
    reg [1:0]         cnt_q;
    reg [1:0]         cnt_d;
    reg [1:0]         state_q;
    reg [1:0]         state_d;

    // one-hot burst states
    localparam [1:0]  ST_IDLE  = 2'b01;
    localparam [1:0]  ST_BURST = 2'b10;

    // bit positions of the resynchronised control group
    localparam        CB_SEL   = 0;
    localparam        CB_CPU   = 1;
    localparam        CB_CTL   = 2;
    localparam        CB_STEP  = 3;
    localparam        CB_UPPER = 4;
    localparam        CB_LOWER = 5;
    localparam        CB_OE    = 6;

    // strobe decode results
    wire              cpu_load;
    wire              ctl_load;
    wire              any_load;
    wire              deselect;
    wire              store_req;
    wire [`WORD_W-1:0] wr_word;

    // decoded access for this cycle
    reg               do_read;
    reg               do_write;
    reg [`ADDR_W-1:0] acc_addr;

    // storage array
    reg [`WORD_W-1:0] mem_q [0:`MEM_DEPTH-1];
    wire [`MEM_AW-1:0] mem_idx;
    wire [`WORD_W-1:0] mem_rd;

    // read queue toward the pins
    wire              rdq_in_ready;
    wire              rdq_out_valid;
    wire              rdq_out_ready;
    wire [`WORD_W-1:0] rdq_out_data;
    assign sel_n     = ctl_s2_q[CB_SEL];
    assign cpu_stb_n = ctl_s2_q[CB_CPU];
    assign ctl_stb_n = ctl_s2_q[CB_CTL];
    assign step_n    = ctl_s2_q[CB_STEP];
    assign upper_n   = ctl_s2_q[CB_UPPER];
    assign lower_n   = ctl_s2_q[CB_LOWER];
    assign oe_n      = ctl_s2_q[CB_OE];

    // burst address: upper bits fixed, low two bits xor the count
    function [`ADDR_W-1:0] burst_addr;
        input [`ADDR_W-1:0] base;
        input [1:0]         cnt;
        begin
            burst_addr = {base[`ADDR_HI:`ADDR_FIXED_LSB],
                          base[`ADDR_LO_W-1:0] ^ cnt};
        end
    endfunction

    // any byte enable low makes a controller load or continuation cycle a write
    function is_store;
        input up_n;
        input lo_n;
        begin
            is_store = ~up_n | ~lo_n;
        end
    endfunction

    // merge the enabled bytes and their parity bits into a stored word
    function [`WORD_W-1:0] merge_word;
        input [`WORD_W-1:0] old_word;
        input [`WORD_W-1:0] new_word;
        input               up_n;
        input               lo_n;
        begin
            merge_word = old_word;
            if (!up_n) begin
                merge_word[`UPPER_MSB:`UPPER_LSB] = new_word[`UPPER_MSB:`UPPER_LSB];
                merge_word[`PAR_UPPER_BIT]        = new_word[`PAR_UPPER_BIT];
            end
            if (!lo_n) begin
                merge_word[`LOWER_MSB:`LOWER_LSB] = new_word[`LOWER_MSB:`LOWER_LSB];
                merge_word[`PAR_LOWER_BIT]        = new_word[`PAR_LOWER_BIT];
            end
        end
    endfunction

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            addr_s1_q <= `ADDR_RST;
            addr_s2_q <= `ADDR_RST;
        end else begin
            addr_s1_q <= addr_in;
            addr_s2_q <= addr_s1_q;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            data_s1_q <= `DATA_OUT_RST;
            data_s2_q <= `DATA_OUT_RST;
            par_s1_q  <= `PAR_OUT_RST;
            par_s2_q  <= `PAR_OUT_RST;
        end else begin
            data_s1_q <= data_in;
            data_s2_q <= data_s1_q;
            par_s1_q  <= parity_bits_in;
            par_s2_q  <= par_s1_q;
        end
    end

    // controls reset to idle and deselected
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctl_s1_q  <= 7'h7f;
            ctl_s2_q  <= 7'h7f;
        end else begin
            // output enable is resynchronised like the rest
            ctl_s1_q  <= {out_en_n, lower_byte_store_n, upper_byte_store_n,
                          burst_step_n, ctl_addr_strobe_n, cpu_addr_strobe_n,
                          chip_sel_n};
            ctl_s2_q  <= ctl_s1_q;
        end
    end

    // strobe decode; processor strobe wins over controller strobe
    assign cpu_load  = ~cpu_stb_n & ~sel_n;
    assign ctl_load  = cpu_stb_n & ~ctl_stb_n & ~sel_n;
    assign any_load  = cpu_load | ctl_load;
    assign deselect  = (~cpu_stb_n | ~ctl_stb_n) & sel_n;
    assign store_req = is_store(upper_n, lower_n);
    assign wr_word   = {par_s2_q, data_s2_q};

    // access decode: loads first, then burst continuation
    always @* begin
        state_d  = state_q;
        base_d   = base_q;
        cnt_d    = cnt_q;
        do_read  = 1'b0;
        do_write = 1'b0;
        acc_addr = burst_addr(base_q, cnt_q);
        if (any_load) begin
            // processor load ignores byte enables and controller strobe
            base_d   = addr_s2_q;
            cnt_d    = `BURST_CNT_RST;
            state_d  = ST_BURST;
            acc_addr = addr_s2_q;
            do_write = ctl_load & store_req;
            do_read  = cpu_load | ~store_req;
        end else if (deselect) begin
            state_d  = ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_d = ST_IDLE;
                end
                ST_BURST: begin
                    // select is not looked at during continuation
                    if (!step_n) begin
                        cnt_d    = cnt_q + `BURST_CNT_STEP;
                        acc_addr = burst_addr(base_q, cnt_d);
                    end else begin
                        acc_addr = burst_addr(base_q, cnt_q);
                    end
                    do_write = store_req;
                    do_read  = ~store_req;
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            base_q   <= `ADDR_RST;
            cnt_q    <= `BURST_CNT_RST;
            state_q  <= ST_IDLE;
        end else begin
            base_q   <= base_d;
            cnt_q    <= cnt_d;
            state_q  <= state_d;
        end
    end

    assign mem_idx = acc_addr[`MEM_AW-1:0];
    assign mem_rd  = mem_q[mem_idx];

    // byte-wise update; the host presents data in the write cycle itself
    always @(posedge clk_sys) begin
        if (do_write) begin
            mem_q[mem_idx] <= merge_word(mem_q[mem_idx], wr_word, upper_n, lower_n);
        end
    end

    // read words wait here until the host enables the outputs
    assign rdq_out_ready = ~oe_n & ~do_write;

    word_queue #(
        .WIDTH (`WORD_W),
        .DEPTH (`RDQ_DEPTH),
        .AW    (`RDQ_AW)
    ) u_read_queue (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .in_valid  (do_read),
        .in_ready  (rdq_in_ready),
        .in_data   (mem_rd),
        .out_valid (rdq_out_valid),
        .out_ready (rdq_out_ready),
        .out_data  (rdq_out_data)
    );

    // pin drivers: float at reset, during writes, on empty queue and disable
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            data_out          <= `DATA_OUT_RST;
            parity_bits_out   <= `PAR_OUT_RST;
            data_oe           <= 1'b0;
            parity_bits_oe    <= 1'b0;
            read_queue_full_q <= 1'b0;
        end else begin
            read_queue_full_q <= ~rdq_in_ready;
            if (rdq_out_valid && rdq_out_ready) begin
                data_out        <= rdq_out_data[`DATA_W-1:0];
                parity_bits_out <= rdq_out_data[`WORD_W-1:`DATA_W];
                data_oe         <= 1'b1;
                parity_bits_oe  <= 1'b1;
            end else begin
                data_oe         <= 1'b0;
                parity_bits_oe  <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// file: design/burst_cache_defines.vh
// constants for the burst cache access block
// assumes a single 50 MHz system clock and active-low asynchronous reset
`ifndef BURST_CACHE_DEFINES_VH
`define BURST_CACHE_DEFINES_VH

// external word address width and the part the counter walks
`define ADDR_W          16
`define ADDR_HI         15
`define ADDR_LO_W       2
`define ADDR_FIXED_LSB  2

// data path: two bytes plus one parity bit per byte
`define BYTE_W          8
`define DATA_W          16
`define PAR_W           2
`define WORD_W          18
`define UPPER_MSB       15
`define UPPER_LSB       8
`define LOWER_MSB       7
`define LOWER_LSB       0
`define PAR_UPPER_BIT   17
`define PAR_LOWER_BIT   16

// storage array size, indexed by the low address bits
`define MEM_AW          6
`define MEM_DEPTH       64

// burst counter reset value and step
`define BURST_CNT_RST   2'h0
`define BURST_CNT_STEP  2'h1

// read data queue toward the pins
`define RDQ_DEPTH       8
`define RDQ_AW          3

// reset values of the pin-side outputs, the input synchronisers and the burst base
`define DATA_OUT_RST    16'h0000
`define PAR_OUT_RST     2'h0
`define ADDR_RST        16'h0000

`endif

// file: design/word_queue.v
// small first-in first-out queue built from flip-flops
// assumes one clock; both sides use valid/ready handshakes
`timescale 1ns/1ns
`default_nettype none

module word_queue #(
    parameter WIDTH = 18,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_sys,
    input  wire             rst_b,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg  [WIDTH-1:0] slot_q [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_q;
    reg  [AW-1:0]    rd_ptr_q;
    reg  [AW:0]      count_q;
    wire             push;
    wire             pop;

    assign in_ready  = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data  = slot_q[rd_ptr_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_q <= count_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_q <= count_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end

    // storage needs no reset; valid is governed by the count
    always @(posedge clk_sys) begin
        if (push) begin
            slot_q[wr_ptr_q] <= in_data;
        end
    end

endmodule

`default_nettype wire

// file: design/zz_unused.v
// holds no logic; the block lives in burst_cache_access.v and word_queue.v
// assumes nothing of its surroundings

// file: dv/burst_cache_access_tb.sv
// self-checking bench for burst_cache_access
// assumes host_bus_model on the two-way pins and the bound checker
`timescale 1ns/1ns
`default_nettype none
module burst_cache_access_tb;
    localparam logic [3:0] CPU_RD = 4'h5, CTL = 4'h9, STEP = 4'he, HOLD = 4'hf, DESEL = 4'hb;
    logic        clk_sys = 1'b0, rst_b = 1'b0, host_drive = 1'b0, out_en_n = 1'b1;
    logic        chip_sel_n = 1'b1, cpu_addr_strobe_n = 1'b1, ctl_addr_strobe_n = 1'b1;
    logic        burst_step_n = 1'b1, upper_byte_store_n = 1'b1, lower_byte_store_n = 1'b1;
    logic [15:0] addr_in = 16'h0000, data_in, data_out, seq = 16'h0001;
    logic [17:0] host_word = 18'h00000;
    logic [1:0]  parity_bits_in, parity_bits_out;
    logic        data_oe, parity_bits_oe, read_queue_full_q;
    logic [17:0] mem [0:63];
    logic [17:0] got [$], exp [$];
    int          failures = 0, samples_checked = 0, cycles = 0;
    burst_cache_access dut (.clk_sys(clk_sys), .rst_b(rst_b), .addr_in(addr_in),
        .chip_sel_n(chip_sel_n), .cpu_addr_strobe_n(cpu_addr_strobe_n),
        .ctl_addr_strobe_n(ctl_addr_strobe_n), .burst_step_n(burst_step_n),
        .upper_byte_store_n(upper_byte_store_n), .lower_byte_store_n(lower_byte_store_n),
        .out_en_n(out_en_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .parity_bits_in(parity_bits_in), .parity_bits_out(parity_bits_out),
        .parity_bits_oe(parity_bits_oe), .read_queue_full_q(read_queue_full_q));
    host_bus_model host (.clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe),
        .parity_bits_out(parity_bits_out), .parity_bits_oe(parity_bits_oe),
        .out_en_n(out_en_n), .host_drive(host_drive), .host_word(host_word),
        .data_in(data_in), .parity_bits_in(parity_bits_in));
    initial forever #10 clk_sys = ~clk_sys;
    always @(negedge clk_sys)
        if (data_oe === 1'b1)
            got.push_back({parity_bits_out, data_out});
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] want);
        samples_checked++;
        if (seen !== want) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, want, seen);
        end
    endtask
    // one pin cycle; s = {cpu strobe, ctl strobe, select, step}, we = {upper, lower}
    task automatic op(input logic [3:0] s, input logic [1:0] we, input logic oe,
                      input logic [15:0] a, input logic [5:0] ea, input logic rec);
        logic [17:0] w;
        w = {seq[1:0], 16'h1357 * seq};
        seq++;
        if (rec && (!s[3] || &we))
            exp.push_back(mem[ea]);
        else if (rec && !we[1])
            {mem[ea][17], mem[ea][15:8]} = {w[17], w[15:8]};
        if (rec && !s[3] == 1'b0 && !we[0] && !(&we))
            {mem[ea][16], mem[ea][7:0]} = {w[16], w[7:0]};
        {cpu_addr_strobe_n, ctl_addr_strobe_n, chip_sel_n, burst_step_n} = s;
        {upper_byte_store_n, lower_byte_store_n} = we;
        out_en_n = oe;
        addr_in = a;
        host_word = w;
        host_drive = ~&we;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic drain();
        repeat (12) op(HOLD, 2'h3, 1'b0, 16'h0000, 6'h00, 1'b0);
        chk("word_count", 18'(got.size()), 18'(exp.size()));
        foreach (exp[i]) chk("read_word", got[i], exp[i]);
        got.delete();
        exp.delete();
    endtask
    task automatic s_deselect();
        op(4'h7, 2'h3, 1'b0, 16'h0004, 6'h00, 1'b0);
        op(DESEL, 2'h0, 1'b0, 16'h0004, 6'h00, 1'b0);
        drain();
    endtask
    task automatic s_writes();
        op(CTL, 2'h0, 1'b1, 16'h8004, 6'h04, 1'b1);
        op(STEP, 2'h0, 1'b1, 16'h0000, 6'h05, 1'b1);
        op(HOLD, 2'h0, 1'b1, 16'h0000, 6'h05, 1'b1);
        op(STEP, 2'h0, 1'b1, 16'h0000, 6'h06, 1'b1);
        op(STEP, 2'h0, 1'b1, 16'h0000, 6'h07, 1'b1);
        op(STEP, 2'h2, 1'b1, 16'h0000, 6'h04, 1'b1);
        op(CTL, 2'h1, 1'b1, 16'h0005, 6'h05, 1'b1);
        op(DESEL, 2'h3, 1'b1, 16'h0000, 6'h00, 1'b0);
    endtask
    task automatic s_burst();
        op(4'h1, 2'h0, 1'b0, 16'h0005, 6'h05, 1'b1);
        op(STEP, 2'h3, 1'b0, 16'hffff, 6'h04, 1'b1);
        op(HOLD, 2'h3, 1'b0, 16'hffff, 6'h04, 1'b1);
        op(STEP, 2'h3, 1'b0, 16'h0000, 6'h07, 1'b1);
        op(STEP, 2'h3, 1'b0, 16'h0000, 6'h06, 1'b1);
        op(STEP, 2'h3, 1'b0, 16'h0000, 6'h05, 1'b1);
        op(DESEL, 2'h3, 1'b0, 16'h0000, 6'h00, 1'b0);
        drain();
    endtask
    task automatic s_cpu_write();
        op(CPU_RD, 2'h3, 1'b1, 16'h0006, 6'h06, 1'b1);
        op(HOLD, 2'h0, 1'b1, 16'h0000, 6'h06, 1'b1);
        op(DESEL, 2'h3, 1'b1, 16'h0000, 6'h00, 1'b0);
        op(CTL, 2'h3, 1'b0, 16'h0006, 6'h06, 1'b1);
        op(DESEL, 2'h3, 1'b0, 16'h0000, 6'h00, 1'b0);
        drain();
    endtask
    task automatic s_fill();
        for (int i = 0; i < 11; i++)
            op(i ? STEP : CPU_RD, 2'h3, 1'b1, 16'h0004, {4'h1, i[1:0]}, i < 8);
        repeat (4) op(DESEL, 2'h3, 1'b1, 16'h0000, 6'h00, 1'b0);
        chk("queue_full", {17'h0, read_queue_full_q}, 18'h00001);
        drain();
        chk("queue_empty", {17'h0, read_queue_full_q}, 18'h00000);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        chk("oe_in_reset", {16'h0, data_oe, parity_bits_oe}, 18'h00000);
        #1;
        rst_b = 1'b1;
        s_deselect();
        s_writes();
        s_burst();
        s_cpu_write();
        s_fill();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: dv/burst_cache_sva.sv
// checker for the pin side of burst_cache_access
// assumes a bind to burst_cache_access, one clock, active-low reset
`timescale 1ns/1ns
`default_nettype none
module burst_cache_sva (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic chip_sel_n,
    input wire logic cpu_addr_strobe_n,
    input wire logic ctl_addr_strobe_n,
    input wire logic upper_byte_store_n,
    input wire logic lower_byte_store_n,
    input wire logic out_en_n,
    input wire logic data_oe,
    input wire logic parity_bits_oe,
    input wire logic read_queue_full_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic loaded_q;
    always @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            loaded_q <= 1'b0;
        else if (!chip_sel_n && (!cpu_addr_strobe_n || !ctl_addr_strobe_n))
            loaded_q <= 1'b1;
    chk_oe_pair: assert property (data_oe == parity_bits_oe)
        else $error("data and parity enables differ");
    chk_reset_float: assert property ($rose(rst_b) |-> !data_oe && !parity_bits_oe)
        else $error("pins driven right after reset");
    chk_never_loaded: assert property (!loaded_q |-> !data_oe)
        else $error("pins driven without a selected load");
    chk_oe_needs_en: assert property (data_oe |->
        (!$past(out_en_n, 3) || !$past(out_en_n, 4) || !$past(out_en_n, 5)))
        else $error("pins driven with output enable off");
    chk_en_off_quiet: assert property (out_en_n [*6] |-> !data_oe)
        else $error("pins driven while output enable high");
    chk_cpu_read_ans: assert property ((!cpu_addr_strobe_n && !chip_sel_n && !out_en_n)
        ##1 !out_en_n [*4] |-> data_oe)
        else $error("processor strobe read gave no word");
    chk_ctl_read_ans: assert property ((!ctl_addr_strobe_n && cpu_addr_strobe_n
        && !chip_sel_n && upper_byte_store_n && lower_byte_store_n && !out_en_n)
        ##1 !out_en_n [*4] |-> data_oe)
        else $error("controller strobe read gave no word");
    chk_fill_quiet: assert property ($rose(read_queue_full_q) |-> !data_oe)
        else $error("queue filled while delivering");
    cover property ($rose(read_queue_full_q));
    cover property (data_oe ##1 data_oe);
    cover property (!ctl_addr_strobe_n && !chip_sel_n && !upper_byte_store_n);
endmodule
bind burst_cache_access burst_cache_sva chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .chip_sel_n(chip_sel_n),
    .cpu_addr_strobe_n(cpu_addr_strobe_n), .ctl_addr_strobe_n(ctl_addr_strobe_n),
    .upper_byte_store_n(upper_byte_store_n), .lower_byte_store_n(lower_byte_store_n),
    .out_en_n(out_en_n), .data_oe(data_oe), .parity_bits_oe(parity_bits_oe),
    .read_queue_full_q(read_queue_full_q));
`default_nettype wire

// file: dv/host_bus_model.sv
// host side of the two-way data and parity pins
// assumes device enables from burst_cache_access and host data from the bench
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
    input  wire logic        clk_sys,
    input  wire logic [15:0] data_out,
    input  wire logic        data_oe,
    input  wire logic [1:0]  parity_bits_out,
    input  wire logic        parity_bits_oe,
    input  wire logic        out_en_n,
    input  wire logic        host_drive,
    input  wire logic [17:0] host_word,
    output var  logic [15:0] data_in,
    output var  logic [1:0]  parity_bits_in
);
    logic [17:0] last_q = 18'h00000;
    wire         drive = host_drive && out_en_n; // host drives only with output enable lifted
    // released lines show the inverse of the last level
    always @(posedge clk_sys)
        last_q <= {parity_bits_in, data_in};
    always @* begin
        data_in = drive ? host_word[15:0] : data_oe ? data_out : ~last_q[15:0];
        parity_bits_in = drive ? host_word[17:16] : parity_bits_oe ? parity_bits_out : ~last_q[17:16];
    end
endmodule
`default_nettype wire
